// ===== logic/cpurf_top.sv
// Programmer-visible register set: general registers, counter and flags.
//
// Functional notes
// - Eight 32-bit general registers, accessed at 32, 16 or 8 bits.
// - Each register splits into independent upper and lower 16-bit halves.
// - Each lower half splits into independent high and low bytes.
// - Register 7 serves as stack pointer yet stays an ordinary register.
// - 24-bit program counter; its lowest bit reads as zero on fetch.
// - Extended control has inert trace and mask bits; bits 6..3 read one.
// - Interrupt mask bit 7 blocks all but the non-maskable interrupt.
// - Exception handling start sets the condition-code interrupt mask.
// - Condition-code bits 6 and 4 are user bits via control instructions.
// - Half-carry flag tracks carry or borrow from bit 3, 11 or 27.
// - Negative flag copies the result sign bit.
// - Zero flag is set when the result is zero.
// - Overflow flag is set on arithmetic overflow, else cleared.
// - Carry flag holds carry, borrow, shifted bit, or bit accumulator.
// - Branch conditions use N, Z, V, C; control ops act on flags.
// - Reset loads counter from vector, clears trace, sets interrupt masks.
// - Other flags and general registers are left uninitialised at reset.
// - Odd word or longword addresses are forced even without error.
// - Bit, BCD digit, byte, word and longword data are supported.
`default_nettype none
module cpurf_top
#(
	parameter int NREGS = cpurf_pkg::GPR_COUNT
)
(
	input  wire logic                         clk,
	input  wire logic                         srst,
	input  wire logic [23:0]                  reset_vector,
	input  wire cpurf_pkg::cpurf_gpr_wr_type  gpr_wr,
	input  wire logic [2:0]                   rd_sel,
	input  wire cpurf_pkg::cpurf_view_type    rd_view,
	input  wire logic                         pc_load,
	input  wire logic [23:0]                  pc_value,
	input  wire logic                         pc_step,
	input  wire logic                         exc_start,
	input  wire cpurf_pkg::cpurf_ctl_op_type  cc_op,
	input  wire cpurf_pkg::cpurf_ctl_op_type  xc_op,
	input  wire logic [7:0]                   ctl_imm,
	input  wire cpurf_pkg::cpurf_alu_req_type alu_req,
	input  wire logic                         flags_keep_hz,
	input  wire logic                         carry_wr,
	input  wire logic                         carry_val,
	input  wire logic [3:0]                   branch_cond,
	input  wire logic                         irq_req,
	input  wire logic                         irq_use_ui,
	input  wire logic                         nmi_req,
	input  wire logic [2:0]                   bit_sel,
	input  wire logic [31:0]                  mem_addr,
	input  wire cpurf_pkg::cpurf_size_type    mem_size,
	input  wire logic [31:0]                  mem_wdata,
	output logic [31:0]                       rd_data,
	output logic [31:0]                       sp_value,
	output logic [23:0]                       fetch_addr,
	output logic [7:0]                        condition_code,
	output logic [7:0]                        extended_control,
	output logic                              branch_taken,
	output logic                              irq_accept,
	output logic                              nmi_accept,
	output logic                              sel_bit,
	output logic [7:0]                        bcd_adjusted,
	output logic [31:0]                       bus_addr,
	output logic [31:0]                       bus_wdata_be
);
	typedef struct packed
	{
		logic [NREGS-1:0][31:0] gpr;
		logic [23:0]            pc;
		logic [7:0]             cc;
		logic [7:0]             xc;
		logic [31:0]            rd;
		logic                   br;
		logic                   irq;
		logic                   nmi;
		logic                   bit_out;
		logic [7:0]             bcd;
		logic [31:0]            addr;
		logic [31:0]            wbe;
	} cpurf_state_type;

	cpurf_state_type            state_ff;
	cpurf_state_type            nxt_state;
	cpurf_pkg::cpurf_flags_type alu_flags;

	cpurf_flag_unit u_flags
	(
		.carry_in (state_ff.cc[cpurf_pkg::CC_C]),
		.req      (alu_req),
		.flags    (alu_flags)
	);

	// Applies a control-register operation to an 8-bit value.
	function automatic logic [7:0] ctl_apply
	(
		input cpurf_pkg::cpurf_ctl_op_type op,
		input logic [7:0]                  cur,
		input logic [7:0]                  imm
	);
		case (op)
			cpurf_pkg::CO_LOAD: ctl_apply = imm;
			cpurf_pkg::CO_AND:  ctl_apply = cur & imm;
			cpurf_pkg::CO_OR:   ctl_apply = cur | imm;
			cpurf_pkg::CO_XOR:  ctl_apply = cur ^ imm;
			default:            ctl_apply = cur;
		endcase
	endfunction

	// Writes one register view; untouched parts keep their value.
	function automatic logic [31:0] view_write
	(
		input cpurf_pkg::cpurf_view_type v,
		input logic [31:0]               cur,
		input logic [31:0]               d
	);
		view_write = cur;
		case (v)
			cpurf_pkg::VW_LONG:  view_write = d;
			cpurf_pkg::VW_EXT:   view_write[31:16] = d[15:0];
			cpurf_pkg::VW_LOW:   view_write[15:0] = d[15:0];
			cpurf_pkg::VW_HBYTE: view_write[15:8] = d[7:0];
			cpurf_pkg::VW_LBYTE: view_write[7:0] = d[7:0];
			default:             view_write = cur;
		endcase
	endfunction

	always_comb
	begin
		logic [31:0] rv;
		logic [7:0]  cc;
		logic        cn;
		logic        cz;
		logic        cv;
		logic        cb;
		logic [7:0]  bsrc;
		logic [7:0]  adj;
		rv = 32'h00000000;
		cc = 8'h00;
		bsrc = 8'h00;
		adj = 8'h00;
		nxt_state = state_ff;
		if (gpr_wr.en)
			nxt_state.gpr[gpr_wr.sel] = view_write(gpr_wr.view,
				state_ff.gpr[gpr_wr.sel], gpr_wr.data);
		rv = state_ff.gpr[rd_sel];
		case (rd_view)
			cpurf_pkg::VW_LONG:  nxt_state.rd = rv;
			cpurf_pkg::VW_EXT:   nxt_state.rd = {16'h0000, rv[31:16]};
			cpurf_pkg::VW_LOW:   nxt_state.rd = {16'h0000, rv[15:0]};
			cpurf_pkg::VW_HBYTE: nxt_state.rd = {24'h000000, rv[15:8]};
			cpurf_pkg::VW_LBYTE: nxt_state.rd = {24'h000000, rv[7:0]};
			default:             nxt_state.rd = rv;
		endcase
		// Stack pointer is just register 7; no separate storage to drift.
		if (pc_load)
			nxt_state.pc = pc_value;
		else if (pc_step)
			nxt_state.pc = state_ff.pc + 24'h000002;
		// Flag updates: arithmetic first, then control ops, then exception.
		cc = state_ff.cc;
		if (alu_req.en)
		begin
			if (!flags_keep_hz)
				cc[cpurf_pkg::CC_H] = alu_flags.h;
			cc[cpurf_pkg::CC_N] = alu_flags.n;
			cc[cpurf_pkg::CC_Z] = alu_flags.z;
			cc[cpurf_pkg::CC_V] = alu_flags.v;
			cc[cpurf_pkg::CC_C] = alu_flags.c;
		end
		if (carry_wr)
			cc[cpurf_pkg::CC_C] = carry_val;
		cc = ctl_apply(cc_op, cc, ctl_imm);
		if (exc_start)
			cc[cpurf_pkg::CC_I] = 1'b1;
		nxt_state.cc = cc;
		// Trace and mask bits are stored but steer nothing.
		nxt_state.xc = ctl_apply(xc_op, state_ff.xc, ctl_imm)
			| cpurf_pkg::XC_ONES_MASK;
		cn = state_ff.cc[cpurf_pkg::CC_N];
		cz = state_ff.cc[cpurf_pkg::CC_Z];
		cv = state_ff.cc[cpurf_pkg::CC_V];
		cb = state_ff.cc[cpurf_pkg::CC_C];
		case (branch_cond)
			4'h0: nxt_state.br = 1'b1;
			4'h1: nxt_state.br = 1'b0;
			4'h2: nxt_state.br = !(cb | cz);
			4'h3: nxt_state.br = cb | cz;
			4'h4: nxt_state.br = !cb;
			4'h5: nxt_state.br = cb;
			4'h6: nxt_state.br = !cz;
			4'h7: nxt_state.br = cz;
			4'h8: nxt_state.br = !cv;
			4'h9: nxt_state.br = cv;
			4'hA: nxt_state.br = !cn;
			4'hB: nxt_state.br = cn;
			4'hC: nxt_state.br = !(cn ^ cv);
			4'hD: nxt_state.br = cn ^ cv;
			4'hE: nxt_state.br = !(cz | (cn ^ cv));
			default: nxt_state.br = cz | (cn ^ cv);
		endcase
		nxt_state.irq = irq_req && !state_ff.cc[cpurf_pkg::CC_I]
			&& !(irq_use_ui && state_ff.cc[cpurf_pkg::CC_UI]);
		nxt_state.nmi = nmi_req;
		// Bit operand and decimal adjust act on the low byte view.
		bsrc = rv[7:0];
		nxt_state.bit_out = bsrc[bit_sel];
		adj = bsrc;
		if (bsrc[3:0] > 4'h9 || state_ff.cc[cpurf_pkg::CC_H])
			adj = adj + 8'h06;
		if (bsrc > 8'h99 || state_ff.cc[cpurf_pkg::CC_C])
			adj = adj + 8'h60;
		nxt_state.bcd = adj;
		// Odd word or longword addresses silently round down.
		nxt_state.addr = mem_addr;
		if (mem_size != cpurf_pkg::SZ_BYTE)
			nxt_state.addr[0] = 1'b0;
		case (mem_size)
			cpurf_pkg::SZ_BYTE: nxt_state.wbe = {mem_wdata[7:0], 24'h000000};
			cpurf_pkg::SZ_WORD: nxt_state.wbe = {mem_wdata[15:0], 16'h0000};
			default:            nxt_state.wbe = mem_wdata;
		endcase
		if (srst)
		begin
			nxt_state.pc = reset_vector;
			nxt_state.xc = cpurf_pkg::XC_RESET;
			nxt_state.cc = state_ff.cc | cpurf_pkg::CC_IMASK;
			nxt_state.br = 1'b0;
			nxt_state.irq = 1'b0;
			nxt_state.nmi = 1'b0;
		end
	end

	// General registers and other flags keep their contents through reset.
	always_ff @(posedge clk)
	begin
		state_ff <= nxt_state;
	end

	always_comb
	begin
		rd_data = state_ff.rd;
		sp_value = state_ff.gpr[cpurf_pkg::SP_INDEX];
		fetch_addr = {state_ff.pc[23:1], 1'b0};
		condition_code = state_ff.cc;
		extended_control = state_ff.xc;
		branch_taken = state_ff.br;
		irq_accept = state_ff.irq;
		nmi_accept = state_ff.nmi;
		sel_bit = state_ff.bit_out;
		bcd_adjusted = state_ff.bcd;
		bus_addr = state_ff.addr;
		bus_wdata_be = state_ff.wbe;
	end
endmodule
`default_nettype wire

// ===== inc/cpurf_pkg.sv
// Package with constants and types for the CPU register file and flags block.
`default_nettype none
package cpurf_pkg;
	localparam int GPR_COUNT  = 8;
	localparam int GPR_WIDTH  = 32;
	localparam int SEL_WIDTH  = 3;
	localparam int PC_WIDTH   = 24;
	localparam logic [2:0] SP_INDEX = 3'h7;
	// Condition-code bit positions.
	localparam int CC_I = 7;
	localparam int CC_UI = 6;
	localparam int CC_H = 5;
	localparam int CC_U = 4;
	localparam int CC_N = 3;
	localparam int CC_Z = 2;
	localparam int CC_V = 1;
	localparam int CC_C = 0;
	// Extended control bit positions and fixed bits.
	localparam int XC_T = 7;
	localparam logic [7:0] XC_ONES_MASK = 8'h78;
	localparam logic [7:0] XC_RESET = 8'h7F;
	localparam logic [7:0] CC_RESET = 8'h80;
	localparam logic [7:0] CC_IMASK = 8'h80;
	localparam logic [23:0] PC_ZERO = 24'h000000;
	// Half-carry tap bit for byte, word and longword.
	localparam int HC_BYTE = 3;
	localparam int HC_WORD = 11;
	localparam int HC_LONG = 27;

	typedef enum logic [1:0]
	{
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} cpurf_size_type;

	// Register view: 32-bit, upper half, lower half, high byte, low byte.
	typedef enum logic [4:0]
	{
		VW_LONG  = 5'h01,
		VW_EXT   = 5'h02,
		VW_LOW   = 5'h04,
		VW_HBYTE = 5'h08,
		VW_LBYTE = 5'h10
	} cpurf_view_type;

	// Control-register operation on condition_code or extended_control.
	typedef enum logic [4:0]
	{
		CO_NONE = 5'h01,
		CO_LOAD = 5'h02,
		CO_AND  = 5'h04,
		CO_OR   = 5'h08,
		CO_XOR  = 5'h10
	} cpurf_ctl_op_type;

	// Arithmetic operation for flag generation.
	typedef enum logic [6:0]
	{
		AO_ADD  = 7'h01,
		AO_ADDX = 7'h02,
		AO_SUB  = 7'h04,
		AO_SUBX = 7'h08,
		AO_CMP  = 7'h10,
		AO_NEG  = 7'h20,
		AO_LOGIC = 7'h40
	} cpurf_alu_op_type;

	typedef struct packed
	{
		logic                 en;
		logic [SEL_WIDTH-1:0] sel;
		cpurf_view_type       view;
		logic [31:0]          data;
	} cpurf_gpr_wr_type;

	typedef struct packed
	{
		logic             en;
		cpurf_alu_op_type op;
		cpurf_size_type   size;
		logic [31:0]      a;
		logic [31:0]      b;
	} cpurf_alu_req_type;

	typedef struct packed
	{
		logic [31:0] result;
		logic        h;
		logic        n;
		logic        z;
		logic        v;
		logic        c;
	} cpurf_flags_type;
endpackage
`default_nettype wire

// ===== logic/cpurf_flag_unit.sv
// Arithmetic result and half-carry, sign, zero, overflow and carry flags.
`default_nettype none
module cpurf_flag_unit
(
	input  wire logic                        carry_in,
	input  wire cpurf_pkg::cpurf_alu_req_type req,
	output var  cpurf_pkg::cpurf_flags_type   flags
);
	always_comb
	begin
		logic [32:0] sum;
		logic [31:0] opa;
		logic [31:0] opb;
		logic [31:0] res;
		logic        sub;
		logic        cin;
		logic        sa;
		logic        sb;
		logic        sr;
		logic [2:0]  hl;
		logic [31:0] hsum;
		int          msb;
		int          ht;
		sum = 33'h000000000;
		opa = req.a;
		opb = req.b;
		res = 32'h00000000;
		sub = 1'b0;
		cin = 1'b0;
		hl = 3'h0;
		hsum = 32'h00000000;
		msb = 31;
		ht = cpurf_pkg::HC_LONG;
		case (req.op)
			cpurf_pkg::AO_ADD: sub = 1'b0;
			cpurf_pkg::AO_ADDX: cin = carry_in;
			cpurf_pkg::AO_SUB, cpurf_pkg::AO_CMP: sub = 1'b1;
			cpurf_pkg::AO_SUBX:
			begin
				sub = 1'b1;
				cin = carry_in;
			end
			cpurf_pkg::AO_NEG:
			begin
				sub = 1'b1;
				opb = req.a;
				opa = 32'h00000000;
			end
			default: sub = 1'b0;
		endcase
		case (req.size)
			cpurf_pkg::SZ_BYTE:
			begin
				msb = 7;
				ht = cpurf_pkg::HC_BYTE;
			end
			cpurf_pkg::SZ_WORD:
			begin
				msb = 15;
				ht = cpurf_pkg::HC_WORD;
			end
			default:
			begin
				msb = 31;
				ht = cpurf_pkg::HC_LONG;
			end
		endcase
		// Subtraction is computed as a + ~b + 1 - borrow; carry is inverted.
		if (sub)
			sum = {1'b0, opa} + {1'b0, ~opb} + {32'h00000000, ~cin};
		else
			sum = {1'b0, opa} + {1'b0, opb} + {32'h00000000, cin};
		res = sum[31:0];
		hsum = opa ^ (sub ? ~opb : opb) ^ res;
		flags.result = res;
		if (req.op == cpurf_pkg::AO_LOGIC)
		begin
			flags.result = req.a;
			res = req.a;
		end
		sa = opa[msb];
		sb = sub ? ~opb[msb] : opb[msb];
		sr = res[msb];
		hl[0] = hsum[ht + 1];
		flags.h = hl[0] ^ sub;
		flags.n = sr;
		case (req.size)
			cpurf_pkg::SZ_BYTE: flags.z = (res[7:0] == 8'h00);
			cpurf_pkg::SZ_WORD: flags.z = (res[15:0] == 16'h0000);
			default: flags.z = (res == 32'h00000000);
		endcase
		flags.v = (sa == sb) && (sr != sa);
		if (msb == 31)
			flags.c = sum[32] ^ sub;
		else
			flags.c = hsum[msb + 1] ^ sub;
		if (req.op == cpurf_pkg::AO_LOGIC)
		begin
			flags.h = 1'b0;
			flags.v = 1'b0;
			flags.c = carry_in;
		end
	end
endmodule
`default_nettype wire

// ===== tb/cpurf_chk.sv
// Concurrent checks on the ports of the register file and flag block.
`default_nettype none
module cpurf_chk
(
	input wire logic                        clk,
	input wire logic                        srst,
	input wire cpurf_pkg::cpurf_gpr_wr_type gpr_wr,
	input wire logic [2:0]                  rd_sel,
	input wire cpurf_pkg::cpurf_view_type   rd_view,
	input wire logic                        exc_start,
	input wire logic                        irq_req,
	input wire logic                        irq_use_ui,
	input wire logic                        nmi_req,
	input wire logic [31:0]                 mem_addr,
	input wire cpurf_pkg::cpurf_size_type   mem_size,
	input wire logic [31:0]                 rd_data,
	input wire logic [31:0]                 sp_value,
	input wire logic [7:0]                  condition_code,
	input wire logic [7:0]                  extended_control,
	input wire logic                        irq_accept,
	input wire logic                        nmi_accept,
	input wire logic [31:0]                 bus_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_wr_long;
		gpr_wr.en && gpr_wr.view == cpurf_pkg::VW_LONG;
	endsequence
	sequence s_rd_same;
		!gpr_wr.en && rd_view == cpurf_pkg::VW_LONG && rd_sel == $past(gpr_wr.sel);
	endsequence
	property p_rd_long;
		s_wr_long ##1 s_rd_same |=> rd_data == $past(gpr_wr.data, 2);
	endproperty
	a_rd_long: assert property (p_rd_long) else $error("read-back differs");
	property p_sp;
		gpr_wr.en && gpr_wr.sel == cpurf_pkg::SP_INDEX
			&& gpr_wr.view == cpurf_pkg::VW_LONG |=> sp_value == $past(gpr_wr.data);
	endproperty
	a_sp: assert property (p_sp) else $error("stack pointer stale");
	property p_reset;
		$fell(srst) |-> extended_control == cpurf_pkg::XC_RESET && condition_code[7];
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset state");
	property p_xc_ones;
		(extended_control & cpurf_pkg::XC_ONES_MASK) == cpurf_pkg::XC_ONES_MASK;
	endproperty
	a_xc_ones: assert property (p_xc_ones) else $error("fixed ones lost");
	property p_exc;
		exc_start |=> condition_code[cpurf_pkg::CC_I];
	endproperty
	a_exc: assert property (p_exc) else $error("mask not set");
	property p_nmi;
		nmi_req |=> nmi_accept;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi not accepted");
	property p_irq;
		1'b1 |=> irq_accept == $past(irq_req && !condition_code[7]
			&& !(irq_use_ui && condition_code[6]));
	endproperty
	a_irq: assert property (p_irq) else $error("irq masking wrong");
	property p_align;
		mem_size != cpurf_pkg::SZ_BYTE |=> bus_addr == ($past(mem_addr) & 32'hFFFFFFFE);
	endproperty
	a_align: assert property (p_align) else $error("odd address kept");
endmodule
bind cpurf_top cpurf_chk cpurf_chk_i (.*);
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the register file and flag block.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                         clk;
	logic                         srst;
	logic [23:0]                  reset_vector;
	cpurf_pkg::cpurf_gpr_wr_type  gpr_wr;
	logic [2:0]                   rd_sel;
	cpurf_pkg::cpurf_view_type    rd_view;
	logic                         pc_load;
	logic [23:0]                  pc_value;
	logic                         pc_step;
	logic                         exc_start;
	cpurf_pkg::cpurf_ctl_op_type  cc_op;
	cpurf_pkg::cpurf_ctl_op_type  xc_op;
	logic [7:0]                   ctl_imm;
	cpurf_pkg::cpurf_alu_req_type alu_req;
	logic                         flags_keep_hz;
	logic                         carry_wr;
	logic                         carry_val;
	logic [3:0]                   branch_cond;
	logic                         irq_req;
	logic                         irq_use_ui;
	logic                         nmi_req;
	logic [2:0]                   bit_sel;
	logic [31:0]                  mem_addr;
	cpurf_pkg::cpurf_size_type    mem_size;
	logic [31:0]                  mem_wdata;
	logic [31:0]                  rd_data;
	logic [31:0]                  sp_value;
	logic [23:0]                  fetch_addr;
	logic [7:0]                   condition_code;
	logic [7:0]                   extended_control;
	logic                         branch_taken;
	logic                         irq_accept;
	logic                         nmi_accept;
	logic                         sel_bit;
	logic [7:0]                   bcd_adjusted;
	logic [31:0]                  bus_addr;
	logic [31:0]                  bus_wdata_be;
	int                           miscompares;
	int                           n_checks;
	cpurf_top cpurf_top_i (.*);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick();
		@(negedge clk);
	endtask
	task automatic wr(input logic [2:0] s, input cpurf_pkg::cpurf_view_type v,
		input logic [31:0] d);
		// The strobe stays up and rd lowers it, so back-to-back writes never
		// drop and raise it again within one time step.
		gpr_wr = {1'b1, s, v, d};
		tick();
	endtask
	task automatic rd(input logic [2:0] s, input logic [31:0] exp);
		gpr_wr.en = 1'b0;
		rd_sel = s;
		tick();
		chk(rd_data, exp);
	endtask
	// Drives one control-register operation and checks the register it hits.
	task automatic ctl(input logic xc, input cpurf_pkg::cpurf_ctl_op_type op,
		input logic [7:0] imm, input logic [7:0] exp);
		cc_op = xc ? cpurf_pkg::CO_NONE : op;
		xc_op = xc ? op : cpurf_pkg::CO_NONE;
		ctl_imm = imm;
		tick();
		cc_op = cpurf_pkg::CO_NONE;
		xc_op = cpurf_pkg::CO_NONE;
		// An idle cycle lets the next call raise its op on a fresh step.
		tick();
		chk(xc ? extended_control : condition_code, exp);
	endtask
	// Only the H, N, Z, V and C positions are compared; user bits are masked.
	task automatic alu(input cpurf_pkg::cpurf_alu_op_type op,
		input cpurf_pkg::cpurf_size_type sz, input logic [31:0] a,
		input logic [31:0] b, input logic [7:0] exp);
		alu_req = {1'b1, op, sz, a, b};
		tick();
		alu_req.en = 1'b0;
		tick();
		chk(condition_code & 8'h2F, exp);
	endtask
	task automatic done(input string name);
		$display("test %s finished, mismatches so far %0d", name, miscompares);
	endtask
	initial
	begin
		repeat (1000) @(posedge clk);
		miscompares++;
		$display("mismatch at %0t: run timed out", $time);
		close_out();
	end
	initial
	begin
		miscompares = 0;
		n_checks = 0;
		srst = 1'b1;
		reset_vector = 24'h123457;
		gpr_wr = '0;
		rd_sel = 3'h0;
		rd_view = cpurf_pkg::VW_LONG;
		{pc_load, pc_step, exc_start, flags_keep_hz, carry_wr} = 5'h00;
		{carry_val, irq_req, irq_use_ui, nmi_req} = 4'h0;
		pc_value = 24'h000000;
		cc_op = cpurf_pkg::CO_NONE;
		xc_op = cpurf_pkg::CO_NONE;
		ctl_imm = 8'h00;
		alu_req = '0;
		branch_cond = 4'h0;
		bit_sel = 3'h0;
		mem_addr = 32'h00000000;
		mem_size = cpurf_pkg::SZ_BYTE;
		mem_wdata = 32'h00000000;
		repeat (2) tick();
		srst = 1'b0;
		chk(extended_control, 8'h7F);
		chk(condition_code[7], 1'b1);
		chk(fetch_addr, 24'h123456);
		done("reset");
		for (int i = 0; i < 8; i++)
			wr(i[2:0], cpurf_pkg::VW_LONG, 32'h11111111 * (i + 1));
		for (int i = 0; i < 8; i++)
			rd(i[2:0], 32'h11111111 * (i + 1));
		chk(sp_value, 32'h88888888);
		wr(3'h7, cpurf_pkg::VW_LONG, 32'h00FFFF00);
		chk(sp_value, 32'h00FFFF00);
		wr(3'h2, cpurf_pkg::VW_EXT, 32'h0000AAAA);
		wr(3'h2, cpurf_pkg::VW_HBYTE, 32'h00000055);
		wr(3'h2, cpurf_pkg::VW_LBYTE, 32'h00000066);
		rd(3'h2, 32'hAAAA5566);
		wr(3'h2, cpurf_pkg::VW_LOW, 32'h00001234);
		rd(3'h2, 32'hAAAA1234);
		rd_view = cpurf_pkg::VW_EXT;
		rd(3'h2, 32'h0000AAAA);
		rd_view = cpurf_pkg::VW_HBYTE;
		rd(3'h2, 32'h00000012);
		rd_view = cpurf_pkg::VW_LBYTE;
		rd(3'h2, 32'h00000034);
		rd_view = cpurf_pkg::VW_LOW;
		rd(3'h2, 32'h00001234);
		rd_view = cpurf_pkg::VW_LONG;
		wr(3'h5, cpurf_pkg::VW_LONG, 32'h5A5AA5A5);
		rd(3'h5, 32'h5A5AA5A5);
		done("registers");
		ctl(1'b0, cpurf_pkg::CO_LOAD, 8'h50, 8'h50);
		ctl(1'b0, cpurf_pkg::CO_AND, 8'h40, 8'h40);
		ctl(1'b0, cpurf_pkg::CO_OR, 8'h11, 8'h51);
		ctl(1'b0, cpurf_pkg::CO_XOR, 8'hFF, 8'hAE);
		exc_start = 1'b1;
		ctl(1'b0, cpurf_pkg::CO_LOAD, 8'h00, 8'h80);
		exc_start = 1'b0;
		ctl(1'b0, cpurf_pkg::CO_LOAD, 8'h00, 8'h00);
		{irq_req, nmi_req} = 2'h3;
		tick();
		chk({irq_accept, nmi_accept}, 2'h3);
		ctl(1'b0, cpurf_pkg::CO_LOAD, 8'h80, 8'h80);
		tick();
		chk({irq_accept, nmi_accept}, 2'h1);
		ctl(1'b0, cpurf_pkg::CO_LOAD, 8'h40, 8'h40);
		irq_use_ui = 1'b1;
		tick();
		chk({irq_accept, nmi_accept}, 2'h1);
		irq_use_ui = 1'b0;
		tick();
		chk({irq_accept, nmi_accept}, 2'h3);
		{irq_req, nmi_req} = 2'h0;
		done("control");
		alu(cpurf_pkg::AO_ADD, cpurf_pkg::SZ_BYTE, 32'h0F, 32'h01, 8'h20);
		alu(cpurf_pkg::AO_ADD, cpurf_pkg::SZ_BYTE, 32'h7F, 32'h01, 8'h2A);
		alu(cpurf_pkg::AO_ADD, cpurf_pkg::SZ_BYTE, 32'hFF, 32'h01, 8'h25);
		alu(cpurf_pkg::AO_LOGIC, cpurf_pkg::SZ_BYTE, 32'h00, 32'h00, 8'h05);
		alu(cpurf_pkg::AO_ADDX, cpurf_pkg::SZ_BYTE, 32'h00, 32'h00, 8'h00);
		alu(cpurf_pkg::AO_SUB, cpurf_pkg::SZ_WORD, 32'h00, 32'h01, 8'h29);
		alu(cpurf_pkg::AO_ADD, cpurf_pkg::SZ_LONG, 32'h0FFFFFFF, 32'h01, 8'h20);
		alu(cpurf_pkg::AO_CMP, cpurf_pkg::SZ_LONG, 32'h05, 32'h05, 8'h04);
		{carry_wr, carry_val} = 2'h3;
		tick();
		carry_wr = 1'b0;
		chk(condition_code[0], 1'b1);
		// Borrow into bit 3 with carry set; then a kept H must survive NEG.
		alu(cpurf_pkg::AO_SUBX, cpurf_pkg::SZ_BYTE, 32'h10, 32'h00, 8'h20);
		flags_keep_hz = 1'b1;
		alu(cpurf_pkg::AO_NEG, cpurf_pkg::SZ_BYTE, 32'h00, 32'h00, 8'h24);
		flags_keep_hz = 1'b0;
		alu(cpurf_pkg::AO_NEG, cpurf_pkg::SZ_BYTE, 32'h80, 32'h00, 8'h0B);
		done("flags");
		// Z and C set, N and V clear: one expected bit per condition code.
		ctl(1'b0, cpurf_pkg::CO_LOAD, 8'h05, 8'h05);
		for (int k = 0; k < 16; k++)
		begin
			branch_cond = k[3:0];
			tick();
			chk(branch_taken, (32'h000095A9 >> k) & 32'h00000001);
		end
		// Register 1 holds 0x22 in its low byte; with C set the adjust adds 0x60.
		rd_sel = 3'h1;
		bit_sel = 3'h1;
		tick();
		chk(sel_bit, 1'b1);
		chk(bcd_adjusted, 8'h82);
		bit_sel = 3'h7;
		tick();
		chk(sel_bit, 1'b0);
		done("branch");
		{mem_addr, mem_size, mem_wdata} = {32'h1235, cpurf_pkg::SZ_WORD, 32'hABCD};
		tick();
		chk(bus_addr, 32'h00001234);
		chk(bus_wdata_be, 32'hABCD0000);
		mem_size = cpurf_pkg::SZ_BYTE;
		tick();
		chk(bus_addr, 32'h00001235);
		chk(bus_wdata_be, 32'hCD000000);
		{pc_load, pc_value, pc_step} = {1'b1, 24'h000101, 1'b1};
		tick();
		pc_load = 1'b0;
		chk(fetch_addr, 24'h000100);
		tick();
		pc_step = 1'b0;
		chk(fetch_addr, 24'h000102);
		done("bus and counter");
		ctl(1'b1, cpurf_pkg::CO_LOAD, 8'h00, 8'h78);
		srst = 1'b1;
		tick();
		srst = 1'b0;
		chk(extended_control, 8'h7F);
		chk(condition_code & 8'h85, 8'h85);
		chk(fetch_addr, 24'h123456);
		done("second reset");
		close_out();
	end
endmodule
`default_nettype wire
